/* logic/dla_consts.svh */
// Constants for the data lane and addressing block
`ifndef DLA_CONSTS_SVH
`define DLA_CONSTS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define DLA_LANES        4
`define DLA_DQ_W         32
`define DLA_CA_W         10
`define DLA_BANK_W       3
`define DLA_ROW_W        14
`define DLA_COL_W        11
`define DLA_LANES_X16    4'h3
`define DLA_LANES_X32    4'hf

// ****************************************************************
// Command address fields
// ****************************************************************
`define DLA_OP_ACT       2'h1
`define DLA_OP_WR        2'h0
`define DLA_OP_RD        2'h2
`define DLA_BANK_LSB     2
`define DLA_ROWHI_LSB    5
`define DLA_ROWLO_W      9

// ****************************************************************
// Beat word layout in the write path
// ****************************************************************
`define DLA_BEAT_W       64
`define DLA_MASK_LSB     32
`define DLA_COL_LSB      36
`define DLA_ROW_LSB      47
`define DLA_BANK_POS     61

// ****************************************************************
// Buffering and reset values
// ****************************************************************
`define DLA_FIFO_DEPTH   8
`define DLA_STROBE_RST   1'b0
`define DLA_TERM_SEL_RST 2'h0

`endif

/* logic/dla_pkg.sv */
// Types shared by the data lane and addressing block
`default_nettype none
package dla_pkg;

	typedef enum logic [1:0] {DLA_RD_IDLE, DLA_RD_PRE, DLA_RD_BURST, DLA_RD_POST} dla_rd_state_t;

	typedef logic [63:0] dla_beat_t;

endpackage : dla_pkg
`default_nettype wire

/* logic/dla_async_fifo.sv */
// Dual clock FIFO with gray pointers and a registered read stage
`timescale 1ns/1ps
`default_nettype none
module dla_async_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
)(
	input  wire logic             wrClk,
	input  wire logic             wrRst_n,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             rdClk,
	input  wire logic             rdRst_n,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] binToGray(input logic [AW:0] b);
		binToGray = b ^ (b >> 1);
	endfunction : binToGray

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wBin_reg;
	logic [AW:0]      wGray_reg;
	logic [AW:0]      rgSync1_reg;
	logic [AW:0]      rgSync2_reg;
	logic [AW:0]      rBin_reg;
	logic [AW:0]      rGray_reg;
	logic [AW:0]      wgSync1_reg;
	logic [AW:0]      wgSync2_reg;
	logic             inReady_reg;
	logic             outValid_reg;
	logic [WIDTH-1:0] outData_reg;

	// ****************************************************************
	// Write side
	// ****************************************************************
	wire              push      = inValid && inReady_reg;
	wire [AW:0]       wBinNext  = push ? wBin_reg + 1'b1 : wBin_reg;
	wire [AW:0]       wGrayNext = binToGray(wBinNext);
	// Ready is computed one edge ahead so it can leave as a plain flop
	wire              fullNext  = wGrayNext == {~rgSync2_reg[AW:AW-1], rgSync2_reg[AW-2:0]};

	always_ff @(posedge wrClk)
	begin
		if (!wrRst_n) begin
			wBin_reg    <= '0;
			wGray_reg   <= '0;
			rgSync1_reg <= '0;
			rgSync2_reg <= '0;
			inReady_reg <= 1'b0;
		end else begin
			wBin_reg    <= wBinNext;
			wGray_reg   <= wGrayNext;
			rgSync1_reg <= rGray_reg;
			rgSync2_reg <= rgSync1_reg;
			inReady_reg <= !fullNext;
		end
	end

	always_ff @(posedge wrClk)
	begin
		if (push)
			mem[wBin_reg[AW-1:0]] <= inData;
	end

	// ****************************************************************
	// Read side
	// ****************************************************************
	wire empty = rGray_reg == wgSync2_reg;
	wire load  = !empty && (!outValid_reg || outReady);
	wire [AW:0] rBinNext = load ? rBin_reg + 1'b1 : rBin_reg;

	always_ff @(posedge rdClk)
	begin
		if (!rdRst_n) begin
			rBin_reg     <= '0;
			rGray_reg    <= '0;
			wgSync1_reg  <= '0;
			wgSync2_reg  <= '0;
			outValid_reg <= 1'b0;
		end else begin
			rBin_reg     <= rBinNext;
			rGray_reg    <= binToGray(rBinNext);
			wgSync1_reg  <= wGray_reg;
			wgSync2_reg  <= wgSync1_reg;
			outValid_reg <= load || (outValid_reg && !outReady);
		end
	end

	always_ff @(posedge rdClk)
	begin
		if (load)
			outData_reg <= mem[rBin_reg[AW-1:0]];
	end

	assign inReady  = inReady_reg;
	assign outValid = outValid_reg;
	assign outData  = outData_reg;

	a_out_hold: assert property (@(posedge rdClk) disable iff (!rdRst_n)
		outValid && !outReady |=> outValid && $stable(outData))
		else $error("FIFO output changed while stalled");

	a_no_overrun: assert property (@(posedge wrClk) disable iff (!wrRst_n)
		wGray_reg == {~rgSync2_reg[AW:AW-1], rgSync2_reg[AW-2:0]} |-> !inReady)
		else $error("FIFO offered ready while full");

endmodule : dla_async_fifo
`default_nettype wire

/* logic/dla_data_lanes.sv */
// Data lanes, strobes, write mask, termination and address decode
`timescale 1ns/1ps
`default_nettype none
`include "dla_consts.svh"
module dla_data_lanes
	import dla_pkg::*;
#(
	parameter bit ORG_X32 = 1'b1
)(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   linkClk,
	input  wire logic [`DLA_CA_W-1:0]   caIn,
	input  wire logic                   chipSelIn_n,
	input  wire logic [`DLA_DQ_W-1:0]   dqIn,
	output var  logic [`DLA_DQ_W-1:0]   dqOut,
	output var  logic [`DLA_LANES-1:0]  dqOe,
	input  wire logic [`DLA_LANES-1:0]  strobeTIn,
	output var  logic [`DLA_LANES-1:0]  strobeTOut,
	output var  logic [`DLA_LANES-1:0]  strobeCOut,
	output var  logic [`DLA_LANES-1:0]  strobeOe,
	input  wire logic [`DLA_LANES-1:0]  writeMaskIn,
	input  wire logic                   termEnableIn,
	output var  logic                   termOn,
	output var  logic [1:0]             termSel,
	output var  logic                   linkStall,
	input  wire logic [1:0]             termMode,
	output var  logic                   wrValid,
	input  wire logic                   wrReady,
	output var  logic [`DLA_DQ_W-1:0]   wrData,
	output var  logic [`DLA_LANES-1:0]  wrByteEn,
	output var  logic [`DLA_BANK_W-1:0] wrBank,
	output var  logic [`DLA_ROW_W-1:0]  wrRow,
	output var  logic [`DLA_COL_W-1:0]  wrCol,
	input  wire logic                   rdValidIn,
	output var  logic                   rdReadyOut,
	input  wire logic [`DLA_DQ_W-1:0]   rdDataIn
);
	// Lanes that exist in the chosen organisation
	localparam logic [3:0] LANE_USE = ORG_X32 ? `DLA_LANES_X32 : `DLA_LANES_X16;

	// x32 has one column bit fewer, so the top one is dropped
	function automatic logic [`DLA_COL_W-1:0] colClip(input logic [`DLA_COL_W-1:0] c);
		colClip = ORG_X32 ? {1'b0, c[`DLA_COL_W-2:0]} : c;
	endfunction : colClip

	// ****************************************************************
	// Link reset and pin synchronisers
	// ****************************************************************
	logic                   lrst1_reg;
	logic                   lrst2_reg;
	logic [`DLA_DQ_W-1:0]   dq1_reg;
	logic [`DLA_DQ_W-1:0]   dq2_reg;
	logic [3:0]             wm1_reg;
	logic [3:0]             wm2_reg;
	logic [3:0]             st1_reg;
	logic [3:0]             st2_reg;
	logic [3:0]             st3_reg;
	logic                   cs1_reg;
	logic                   cs2_reg;
	logic [`DLA_CA_W-1:0]   caR1_reg;
	logic [`DLA_CA_W-1:0]   caR2_reg;
	logic [`DLA_CA_W-1:0]   caF1_reg;
	logic [`DLA_CA_W-1:0]   caF2_reg;
	logic                   te1_reg;
	logic                   te2_reg;
	logic [1:0]             tm1_reg;
	logic [1:0]             tm2_reg;

	wire                    linkRst_n = lrst2_reg;

	always_ff @(posedge linkClk)
	begin
		lrst1_reg <= rst_n;
		lrst2_reg <= lrst1_reg;
		dq1_reg   <= dqIn;
		dq2_reg   <= dq1_reg;
		wm1_reg   <= writeMaskIn;
		wm2_reg   <= wm1_reg;
		st1_reg   <= strobeTIn;
		st2_reg   <= st1_reg;
		st3_reg   <= st2_reg;
		cs1_reg   <= chipSelIn_n;
		cs2_reg   <= cs1_reg;
		caR1_reg  <= caIn;
		caR2_reg  <= caR1_reg;
		te1_reg   <= termEnableIn;
		te2_reg   <= te1_reg;
		tm1_reg   <= termMode;
		tm2_reg   <= tm1_reg;
	end

	// Falling half of the command word; select is never looked at here
	always_ff @(negedge linkClk)
	begin
		caF1_reg <= caIn;
		caF2_reg <= caF1_reg;
	end

	// ****************************************************************
	// Command and address decode
	// ****************************************************************
	logic                   wrBurst_reg;
	logic [`DLA_BANK_W-1:0] bank_reg;
	logic [`DLA_ROW_W-1:0]  row_reg;
	logic [`DLA_COL_W-1:0]  col_reg;

	wire       cmdSel  = !cs2_reg;
	wire [1:0] opcode  = caR2_reg[1:0];
	wire       actCmd  = cmdSel && opcode == `DLA_OP_ACT;
	wire       wrCmd   = cmdSel && opcode == `DLA_OP_WR;
	wire       rdCmd   = cmdSel && opcode == `DLA_OP_RD;
	wire [`DLA_BANK_W-1:0] cmdBank = caR2_reg[`DLA_BANK_LSB +: `DLA_BANK_W];
	wire [`DLA_ROW_W-1:0]  cmdRow  = {caR2_reg[`DLA_CA_W-1:`DLA_ROWHI_LSB],
		caF2_reg[`DLA_ROWLO_W-1:0]};
	wire [`DLA_COL_W-1:0]  cmdCol  = colClip({caF2_reg, 1'b0});

	// ****************************************************************
	// Write beat capture, one strobe per lane
	// ****************************************************************
	logic [`DLA_DQ_W-1:0]   laneData_reg;
	logic [3:0]             laneMask_reg;
	logic [3:0]             laneHit_reg;
	logic                   stall_reg;
	logic [`DLA_DQ_W-1:0]   beatData;
	logic [3:0]             beatMask;
	logic                   wInReady;

	// Both edges of the true strobe count as a beat
	wire [3:0] strobeEdge = (st2_reg ^ st3_reg) & LANE_USE;
	wire [3:0] hitNow     = (laneHit_reg | strobeEdge) & LANE_USE;
	wire       beatDone   = wrBurst_reg && strobeEdge != 4'h0 && hitNow == LANE_USE;
	wire       wInValid   = beatDone;

	genvar gi;
	generate
		for (gi = 0; gi < `DLA_LANES; gi++) begin : g_lane
			assign beatData[gi*8 +: 8] = strobeEdge[gi] ? dq2_reg[gi*8 +: 8] :
				laneData_reg[gi*8 +: 8];
			assign beatMask[gi] = strobeEdge[gi] ? wm2_reg[gi] : laneMask_reg[gi];
		end
	endgenerate

	always_ff @(posedge linkClk)
	begin
		if (!linkRst_n) begin
			laneHit_reg <= 4'h0;
			wrBurst_reg <= 1'b0;
			stall_reg   <= 1'b0;
		end else begin
			laneHit_reg <= (beatDone || wrCmd) ? 4'h0 : hitNow;
			stall_reg   <= !wInReady;
			if (wrCmd)
				wrBurst_reg <= 1'b1;
			else if (actCmd || rdCmd)
				wrBurst_reg <= 1'b0;
		end
	end

	always_ff @(posedge linkClk)
	begin
		laneData_reg <= beatData;
		laneMask_reg <= beatMask;
	end

	// Column advances by one beat; x32 wraps inside its ten bits
	always_ff @(posedge linkClk)
	begin
		if (!linkRst_n) begin
			bank_reg <= '0;
			row_reg  <= '0;
			col_reg  <= '0;
		end else begin
			if (actCmd || wrCmd)
				bank_reg <= cmdBank;
			if (actCmd)
				row_reg <= cmdRow;
			if (wrCmd)
				col_reg <= cmdCol;
			else if (beatDone)
				col_reg <= colClip(col_reg + 1'b1);
		end
	end

	// ****************************************************************
	// Crossings between link and core
	// ****************************************************************
	dla_beat_t wBeatIn;
	dla_beat_t wBeatOut;
	logic      wOutValid;
	logic      wOutReady;
	logic      rOutValid;
	logic      rOutReady;
	logic [`DLA_DQ_W-1:0] rOutData;

	assign wBeatIn = {bank_reg, row_reg, col_reg, beatMask, beatData};

	// A full buffer cannot hold off the controller, so it raises linkStall
	dla_async_fifo #(
		.WIDTH (`DLA_BEAT_W),
		.DEPTH (`DLA_FIFO_DEPTH)
	) u_wr_fifo (
		.wrClk    (linkClk),
		.wrRst_n  (linkRst_n),
		.inValid  (wInValid),
		.inReady  (wInReady),
		.inData   (wBeatIn),
		.rdClk    (clk),
		.rdRst_n  (rst_n),
		.outValid (wOutValid),
		.outReady (wOutReady),
		.outData  (wBeatOut)
	);

	dla_async_fifo #(
		.WIDTH (`DLA_DQ_W),
		.DEPTH (`DLA_FIFO_DEPTH)
	) u_rd_fifo (
		.wrClk    (clk),
		.wrRst_n  (rst_n),
		.inValid  (rdValidIn),
		.inReady  (rdReadyOut),
		.inData   (rdDataIn),
		.rdClk    (linkClk),
		.rdRst_n  (linkRst_n),
		.outValid (rOutValid),
		.outReady (rOutReady),
		.outData  (rOutData)
	);

	// ****************************************************************
	// Core side write port
	// ****************************************************************
	logic                   wrValid_reg;
	logic [`DLA_DQ_W-1:0]   wrData_reg;
	logic [3:0]             wrByteEn_reg;
	logic [`DLA_BANK_W-1:0] wrBank_reg;
	logic [`DLA_ROW_W-1:0]  wrRow_reg;
	logic [`DLA_COL_W-1:0]  wrCol_reg;

	assign wOutReady = !wrValid_reg || wrReady;
	wire wTake     = wOutValid && wOutReady;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wrValid_reg <= 1'b0;
		else
			wrValid_reg <= wTake || (wrValid_reg && !wrReady);
	end

	always_ff @(posedge clk)
	begin
		if (wTake) begin
			wrData_reg   <= wBeatOut[`DLA_DQ_W-1:0];
			// Masked lanes lose their enable and are never written
			wrByteEn_reg <= ~wBeatOut[`DLA_MASK_LSB +: 4] & LANE_USE;
			wrCol_reg    <= wBeatOut[`DLA_COL_LSB +: `DLA_COL_W];
			wrRow_reg    <= wBeatOut[`DLA_ROW_LSB +: `DLA_ROW_W];
			wrBank_reg   <= wBeatOut[`DLA_BANK_POS +: `DLA_BANK_W];
		end
	end

	// ****************************************************************
	// Read drive on the link
	// ****************************************************************
	dla_rd_state_t rdState_reg;
	dla_rd_state_t rdState_next;
	logic [`DLA_DQ_W-1:0] dqOut_reg;
	logic [3:0]           dqOe_reg;
	logic [3:0]           strobeT_reg;
	logic [3:0]           strobeC_reg;
	logic                 termOn_reg;
	logic [1:0]           termSel_reg;

	wire rdPop = rdState_reg == DLA_RD_BURST && rOutValid;
	assign rOutReady = rdState_reg == DLA_RD_BURST;

	always_comb
	begin
		rdState_next = rdState_reg;
		unique case (rdState_reg)
			DLA_RD_IDLE:  if (rOutValid) rdState_next = DLA_RD_PRE;
			DLA_RD_PRE:   rdState_next = DLA_RD_BURST;
			DLA_RD_BURST: if (!rOutValid) rdState_next = DLA_RD_POST;
			DLA_RD_POST:  rdState_next = DLA_RD_IDLE;
		endcase
	end

	wire       driveNext   = rdState_next != DLA_RD_IDLE;
	// Strobe toggles on the same edge as the data, so edges line up
	wire [3:0] strobeTNext = rdPop ? ~strobeT_reg :
		(rdState_reg == DLA_RD_IDLE ? {4{`DLA_STROBE_RST}} : strobeT_reg);

	always_ff @(posedge linkClk)
	begin
		if (!linkRst_n) begin
			rdState_reg <= DLA_RD_IDLE;
			dqOe_reg    <= 4'h0;
			strobeT_reg <= {4{`DLA_STROBE_RST}};
			strobeC_reg <= {4{~`DLA_STROBE_RST}};
			termOn_reg  <= 1'b0;
			termSel_reg <= `DLA_TERM_SEL_RST;
		end else begin
			rdState_reg <= rdState_next;
			dqOe_reg    <= driveNext ? LANE_USE : 4'h0;
			strobeT_reg <= strobeTNext & LANE_USE;
			strobeC_reg <= ~strobeTNext & LANE_USE;
			// Termination stays off while the device itself drives
			termOn_reg  <= te2_reg && tm2_reg != 2'h0 && !driveNext;
			termSel_reg <= tm2_reg;
		end
	end

	always_ff @(posedge linkClk)
	begin
		if (rdPop)
			dqOut_reg <= ORG_X32 ? rOutData : {16'h0000, rOutData[15:0]};
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign dqOut      = dqOut_reg;
	assign dqOe       = dqOe_reg;
	assign strobeTOut = strobeT_reg;
	assign strobeCOut = strobeC_reg;
	assign strobeOe   = dqOe_reg;
	assign termOn     = termOn_reg;
	assign termSel    = termSel_reg;
	assign linkStall  = stall_reg;
	assign wrValid    = wrValid_reg;
	assign wrData     = wrData_reg;
	assign wrByteEn   = wrByteEn_reg;
	assign wrBank     = wrBank_reg;
	assign wrRow      = wrRow_reg;
	assign wrCol      = wrCol_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_pop;
		rdPop;
	endsequence
	sequence s_edge_with_data;
		##1 strobeTOut != $past(strobeTOut) && dqOut == $past(rOutData);
	endsequence

	a_upper_lanes_off: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		!ORG_X32 |-> dqOe[3:2] == 2'h0 && strobeOe[3:2] == 2'h0 && strobeTOut[3:2] == 2'h0)
		else $error("Unused upper lanes driven in x16");
	a_strobe_pair: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		strobeOe[0] |-> strobeCOut[0] == ~strobeTOut[0])
		else $error("Strobe pair not complementary");
	a_read_aligned: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		s_pop |-> s_edge_with_data)
		else $error("Read strobe edge not aligned with data");
	a_mask_drops: assert property (@(posedge clk) disable iff (!rst_n)
		wTake |=> wrByteEn == (~$past(wBeatOut[35:32]) & LANE_USE))
		else $error("Masked lane still enabled");
	a_wr_hold: assert property (@(posedge clk) disable iff (!rst_n)
		wrValid && !wrReady |=> wrValid && $stable(wrByteEn) && $stable(wrData))
		else $error("Write beat changed while stalled");
	a_beat_edge: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		wInValid |-> strobeEdge != 4'h0 && wrBurst_reg)
		else $error("Beat taken without a strobe edge");
	a_col_lsb_zero: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		wrCmd |=> col_reg[0] == 1'b0 && (!ORG_X32 || col_reg[10] == 1'b0))
		else $error("Column start bit not zero");
	a_term_follow: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		!te2_reg |=> !termOn)
		else $error("Termination on without enable");
	a_act_row: assert property (@(posedge linkClk) disable iff (!linkRst_n)
		actCmd |=> row_reg == $past(cmdRow) && bank_reg == $past(cmdBank))
		else $error("Row or bank not taken on activate");

endmodule : dla_data_lanes
`default_nettype wire

/* bench/dla_ctl_model.sv */
// Memory controller model for the link side of the data lane block
`timescale 1ns/1ps
`default_nettype none
`include "dla_consts.svh"
module dla_ctl_model (
	input  wire logic                 linkClk,
	output var  logic [`DLA_CA_W-1:0] caDrv,
	output var  logic                 csDrv_n,
	output var  logic [31:0]          dqDrv,
	output var  logic [3:0]           strobeDrv,
	output var  logic [3:0]           maskDrv,
	output var  logic                 termEnable,
	input  wire logic [31:0]          dqPins,
	input  wire logic [3:0]           devOe,
	input  wire logic [3:0]           devStrobeT,
	input  wire logic [3:0]           devStrobeC
);
	logic [31:0] rdQ[$];
	logic [3:0]  strobePrev;
	logic [3:0]  oePrev;
	int          pairFaults;

	initial
	begin
		caDrv = '0;
		csDrv_n = 1'b1;
		dqDrv = '0;
		strobeDrv = '0;
		maskDrv = '0;
		termEnable = 1'b0;
		strobePrev = '0;
		oePrev = '0;
		pairFaults = 0;
	end

	// ********
	// Commands: rising half, then falling half; column LSB never sent
	// ********
	task automatic command(input logic [9:0] rise, input logic [9:0] fall);
		@(negedge linkClk);
		caDrv <= rise;
		csDrv_n <= 1'b0;
		dqDrv <= ~dqDrv;
		@(posedge linkClk);
		caDrv <= fall;
		csDrv_n <= 1'b1;
		@(negedge linkClk);
		// Released bus shows a moving pattern, not the last value
		caDrv <= ~fall;
	endtask : command

	// ********
	// Write beat: all 32 lines, every lane strobe toggled mid-bit
	// ********
	task automatic beat(input logic [31:0] d, input logic [3:0] m, input int gap);
		@(posedge linkClk);
		dqDrv <= d;
		maskDrv <= m;
		@(negedge linkClk);
		strobeDrv <= ~strobeDrv;
		repeat (gap) @(posedge linkClk);
	endtask : beat

	task automatic setTerm(input logic en);
		@(posedge linkClk);
		termEnable <= en;
	endtask : setTerm

	// ********
	// Read capture; PRE cycle is skipped because oe was low before it
	// ********
	always @(negedge linkClk)
	begin
		strobePrev <= devStrobeT;
		oePrev <= devOe;
		if (devOe === 4'hf && devStrobeC !== ~devStrobeT)
			pairFaults <= pairFaults + 1;
		if (devOe === 4'hf && oePrev === 4'hf && devStrobeT !== strobePrev)
			rdQ.push_back(dqPins);
	end
endmodule : dla_ctl_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the data lane block
`timescale 1ns/1ps
`default_nettype none
`include "dla_consts.svh"
module tb
	import dla_pkg::*;
;
	logic        clk = 1'b0;
	logic        linkClk = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  caIn;
	logic        chipSelIn_n;
	logic [31:0] dqIn, dqOut, ctlDq, wrData;
	logic [31:0] rdDataIn = '0;
	logic [3:0]  dqOe, strobeTIn, strobeTOut, strobeCOut, strobeOe, ctlStrobe;
	logic [3:0]  writeMaskIn, wrByteEn;
	logic        termEnableIn, termOn, linkStall, wrValid, rdReadyOut;
	logic [1:0]  termSel;
	logic [1:0]  termMode = 2'h0;
	logic        wrReady = 1'b1;
	logic        rdValidIn = 1'b0;
	logic [2:0]  wrBank;
	logic [13:0] wrRow;
	logic [10:0] wrCol;
	dla_beat_t   got[$];
	int          failCount = 0;
	int          comparisons = 0;

	always #4 clk = ~clk;
	initial
	begin
		#3;
		forever #15 linkClk = ~linkClk;
	end

	// ********
	// Pin resolution: whoever enables a lane owns it
	// ********
	always_comb
		for (int i = 0; i < 4; i++)
		begin
			dqIn[8*i +: 8] = dqOe[i] ? dqOut[8*i +: 8] : ctlDq[8*i +: 8];
			strobeTIn[i] = strobeOe[i] ? strobeTOut[i] : ctlStrobe[i];
		end

	dla_data_lanes #(.ORG_X32(1'b1)) dla_data_lanes_i (
		.clk(clk), .rst_n(rst_n), .linkClk(linkClk), .caIn(caIn),
		.chipSelIn_n(chipSelIn_n), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
		.strobeTIn(strobeTIn), .strobeTOut(strobeTOut), .strobeCOut(strobeCOut),
		.strobeOe(strobeOe), .writeMaskIn(writeMaskIn), .termEnableIn(termEnableIn),
		.termOn(termOn), .termSel(termSel), .linkStall(linkStall), .termMode(termMode),
		.wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .wrByteEn(wrByteEn),
		.wrBank(wrBank), .wrRow(wrRow), .wrCol(wrCol), .rdValidIn(rdValidIn),
		.rdReadyOut(rdReadyOut), .rdDataIn(rdDataIn));

	dla_ctl_model dla_ctl_model_i (
		.linkClk(linkClk), .caDrv(caIn), .csDrv_n(chipSelIn_n), .dqDrv(ctlDq),
		.strobeDrv(ctlStrobe), .maskDrv(writeMaskIn), .termEnable(termEnableIn),
		.dqPins(dqIn), .devOe(dqOe), .devStrobeT(strobeTOut), .devStrobeC(strobeCOut));

	// ********
	// Checking and closing
	// ********
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			failCount++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic giveVerdict;
		$display("Checks %0d, mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : giveVerdict

	task automatic hang;
		failCount++;
		$display("Error at %0t: wait ran out", $time);
		giveVerdict;
	endtask : hang

	function automatic logic [31:0] laneBits(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : laneBits

	task automatic collect(input int n);
		int w;
		w = 0;
		got.delete();
		while (got.size() < n && w < 3000)
		begin
			@(posedge clk);
			if (wrValid === 1'b1 && wrReady === 1'b1)
				got.push_back({wrBank, wrRow, wrCol, wrByteEn, wrData});
			w++;
		end
		if (w >= 3000)
			hang;
	endtask : collect

	task automatic pushWord(input logic [31:0] w);
		int n;
		n = 0;
		rdValidIn <= 1'b1;
		rdDataIn <= w;
		@(posedge clk);
		while (rdReadyOut !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 200)
			hang;
	endtask : pushWord

	// ********
	// Scenarios
	// ********
	task automatic scWriteBurst;
		logic [3:0] masks[4];
		logic [3:0] be;
		logic [9:0] c;
		masks = '{4'h0, 4'h1, 4'ha, 4'h6};
		fork
			begin
				dla_ctl_model_i.command({5'h15, 3'h5, 2'h1}, 10'h3a5);
				dla_ctl_model_i.command({5'h1f, 3'h5, 2'h0}, 10'h3ff);
				for (int k = 0; k < 4; k++)
					dla_ctl_model_i.beat(32'h11223344 + 32'(k), masks[k], 3 + 3 * (k % 2));
				dla_ctl_model_i.command({5'h00, 3'h0, 2'h2}, 10'h000);
			end
			collect(4);
		join
		// Column starts at the 10-bit top so the wrap is exercised
		for (int k = 0; k < 4; k++)
		begin
			be = ~masks[k];
			c = 10'h3fe + 10'(k);
			check(got[k][63:32], {3'h5, 5'h15, 9'h1a5, 1'b0, c, be}, "beat address");
			check(got[k][31:0] & laneBits(be), (32'h11223344 + 32'(k)) & laneBits(be),
				"beat data");
		end
	endtask : scWriteBurst

	task automatic scStall;
		logic seenStall;
		seenStall = 1'b0;
		@(posedge clk);
		wrReady <= 1'b0;
		dla_ctl_model_i.command({5'h00, 3'h2, 2'h1}, 10'h000);
		dla_ctl_model_i.command({5'h00, 3'h2, 2'h0}, 10'h000);
		for (int k = 0; k < 12; k++)
		begin
			dla_ctl_model_i.beat(32'ha0b0c0d0 + 32'(k), 4'h0, 3);
			seenStall |= linkStall;
		end
		dla_ctl_model_i.command({5'h00, 3'h0, 2'h2}, 10'h000);
		check(seenStall, 1'b1, "full buffer flagged");
		@(posedge clk);
		wrReady <= 1'b1;
		collect(8);
		for (int k = 0; k < 8; k++)
			check(got[k][31:0], 32'ha0b0c0d0 + 32'(k), "oldest beats kept");
		repeat (60) @(posedge clk);
		check({wrValid, linkStall}, 2'h0, "buffer drained");
	endtask : scStall

	task automatic scRead;
		int n;
		n = 0;
		@(posedge clk);
		for (int k = 0; k < 4; k++)
			pushWord(32'hc3a50f00 + 32'(k) * 32'h01010101);
		rdValidIn <= 1'b0;
		while (dla_ctl_model_i.rdQ.size() < 4 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 300)
			hang;
		repeat (40) @(posedge clk);
		check(dla_ctl_model_i.rdQ.size(), 4, "read word count");
		for (int k = 0; k < 4 && k < dla_ctl_model_i.rdQ.size(); k++)
			check(dla_ctl_model_i.rdQ[k], 32'hc3a50f00 + 32'(k) * 32'h01010101,
				"read word");
		check(dla_ctl_model_i.pairFaults, 0, "strobe pair");
		check({dqOe, strobeOe}, 8'h00, "read drive released");
	endtask : scRead

	task automatic scTerm;
		for (int m = 0; m < 4; m++)
			for (int e = 0; e < 2; e++)
			begin
				@(posedge clk);
				termMode <= m[1:0];
				dla_ctl_model_i.setTerm(e[0]);
				repeat (20) @(posedge clk);
				check(termOn, e[0] && m != 0, "termination state");
				check(termSel, m[1:0], "termination mode");
			end
	endtask : scTerm

	// ********
	// Main sequence; reset spans four link clock edges as well
	// ********
	initial
	begin
		repeat (16) @(posedge clk);
		check({dqOe, strobeOe, strobeTOut, strobeCOut, termOn, wrValid, rdReadyOut, linkStall},
			{12'h000, 4'hf, 4'h0}, "reset outputs");
		rst_n <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		check(rdReadyOut, 1'b1, "read buffer ready");
		repeat (4) @(posedge linkClk);
		scWriteBurst;
		scStall;
		scRead;
		scTerm;
		giveVerdict;
	end
endmodule : tb
`default_nettype wire
